// ### dv/etb_core_model.sv
// Processor side model: trace events and SRAM requests
`timescale 1ns/1ps
module etb_core_model #(
	parameter int AW = 10 // Word address width
) (
	input  wire logic          pclk,         // Clock
	input  wire logic          trace_ready,  // Room
	input  wire logic          cpu_gnt,      // Grant
	input  wire logic [31:0]   cpu_rdata,    // Read data
	input  wire logic          cpu_rvalid,   // Read valid
	output logic               trace_valid,  // Event
	output logic      [31:0]   trace_src_pc, // Source
	output logic      [31:0]   trace_dst_pc, // Target
	output logic               trace_excp,   // Exception
	output logic               cpu_req,      // Request
	output logic               cpu_we,       // Write
	output logic      [AW-1:0] cpu_addr,     // Address
	output logic      [31:0]   cpu_wdata     // Write data
);
	initial
	begin
		{trace_valid, trace_src_pc, trace_dst_pc, trace_excp} = '0;
		{cpu_req, cpu_we, cpu_addr, cpu_wdata} = '0;
	end
	// Event held until taken; data inverted after so stale values never match
	task automatic branch(input logic [31:0] s, input logic [31:0] d, input logic x);
		@(posedge pclk);
		trace_valid <= 1'b1;
		trace_src_pc <= s;
		trace_dst_pc <= d;
		trace_excp <= x;
		do @(posedge pclk); while (trace_ready !== 1'b1);
		trace_valid <= 1'b0;
		trace_src_pc <= ~s;
		trace_dst_pc <= ~d;
	endtask
	// Request held until granted, as a stalled processor must
	task automatic cpu_acc(input logic w, input logic [AW-1:0] a, input logic [31:0] wd, output logic [31:0] rd);
		@(posedge pclk);
		cpu_req <= 1'b1;
		cpu_we <= w;
		cpu_addr <= a;
		cpu_wdata <= wd;
		do @(posedge pclk); while (cpu_gnt !== 1'b1);
		cpu_req <= 1'b0;
		cpu_addr <= ~a;
		cpu_wdata <= ~wd;
		if (!w)
		begin
			do @(posedge pclk); while (cpu_rvalid !== 1'b1);
		end
		rd = cpu_rdata;
	endtask
endmodule // etb_core_model

// ### dv/etb_props.sv
// Port assertions of the execution trace buffer
`timescale 1ns/1ps
`include "etb_params.svh"
module etb_props
	import etb_pkg::*;
#(
	parameter int           AW        = 10,           // Word address width
	parameter etb_word_type SRAM_BASE = 32'h2000_0000 // SRAM place
) (
	input wire logic         pclk,        // Clock
	input wire logic         presetn,     // Reset
	input wire logic         psel,        // Select
	input wire logic         penable,     // Access
	input wire logic         pwrite,      // Direction
	input wire logic [31:0]  paddr,       // Address
	input wire logic [31:0]  pwdata,      // Write data
	input wire logic         pready,      // Ready
	input wire etb_word_type prdata,      // Read data
	input wire logic         pslverr,     // Error
	input wire logic         trace_valid, // Event
	input wire logic         trace_ready, // Room
	input wire logic         cpu_req,     // Request
	input wire logic         cpu_we,      // Write
	input wire logic         cpu_gnt,     // Grant
	input wire logic         cpu_rvalid,  // Read valid
	input wire logic         halt_req     // Halt
);
	////////////////////////////////////////////////////////////
	// Decode and shadow of the enable bit; hardware stop is not seen here
	logic        en_q;
	logic        en_d;
	logic        map;
	logic        mst_wr;
	logic [11:0] off;
	assign off = paddr[11:0];
	assign map = ((paddr & 32'hffff_f000) == `ETB_BASE_ADDR) && (off inside {`ETB_OFF_POSITION,
		`ETB_OFF_MASTER, `ETB_OFF_FLOW, `ETB_OFF_BASE, `ETB_OFF_BUFCFG});
	assign mst_wr = psel && penable && pwrite && map && (off == `ETB_OFF_MASTER);
	always_comb
	begin
		en_d = mst_wr ? pwdata[`ETB_MASTER_EN_BIT] : en_q;
	end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			en_q <= 1'b0;
		else
			en_q <= en_d;
	end
	////////////////////////////////////////////////////////////
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_take;
		trace_valid && trace_ready && en_q && !halt_req;
	endsequence
	sequence s_rd_taken;
		cpu_req && cpu_gnt && !cpu_we;
	endsequence
	property p_err;
		psel && penable |-> pready && (pslverr == !map);
	endproperty
	a_err: assert property (p_err) else $error("pslverr or pready wrong in access");
	property p_err_idle;
		!(psel && penable) |-> !pslverr;
	endproperty
	a_err_idle: assert property (p_err_idle) else $error("pslverr outside access");
	property p_base;
		psel && !penable && !pwrite && map && off == `ETB_OFF_BASE |=> prdata == SRAM_BASE;
	endproperty
	a_base: assert property (p_base) else $error("location register wrong");
	property p_prio;
		s_take |-> ##[1:2] !cpu_gnt;
	endproperty
	a_prio: assert property (p_prio) else $error("processor granted over trace write");
	property p_gnt;
		cpu_gnt |-> cpu_req;
	endproperty
	a_gnt: assert property (p_gnt) else $error("grant without request");
	property p_rv;
		s_rd_taken |=> cpu_rvalid;
	endproperty
	a_rv: assert property (p_rv) else $error("read data late");
	property p_rv_only;
		cpu_rvalid |-> $past(cpu_req && cpu_gnt && !cpu_we);
	endproperty
	a_rv_only: assert property (p_rv_only) else $error("read valid without read");
	property p_halt_clr;
		mst_wr && pwdata[`ETB_MASTER_EN_BIT] && !en_q |=> !halt_req;
	endproperty
	a_halt_clr: assert property (p_halt_clr) else $error("halt not cleared");
endmodule // etb_props

bind execution_trace_buffer etb_props #(.AW(AW), .SRAM_BASE(SRAM_BASE)) i_props (.pclk, .presetn, .psel,
	.penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .trace_valid, .trace_ready, .cpu_req,
	.cpu_we, .cpu_gnt, .cpu_rvalid, .halt_req);

// ### dv/tb.sv
// Register, trace and SRAM sharing tests of the execution trace buffer
`timescale 1ns/1ps
`include "etb_params.svh"
module tb;
	import etb_pkg::*;
	localparam int           AW = 10;
	localparam etb_word_type SB = 32'h2000_0000; // Arbitrary SRAM place
	logic                    pclk, presetn, psel, penable, pwrite;
	logic         [31:0]     paddr, pwdata;
	logic                    pready, pslverr, trace_valid, trace_excp, trace_ready, cpu_req, cpu_we;
	logic                    cpu_gnt, cpu_rvalid, halt_req;
	logic         [31:0]     trace_src_pc, trace_dst_pc, cpu_wdata;
	logic         [AW-1:0]   cpu_addr;
	etb_word_type            prdata, cpu_rdata;
	int                      error_cnt, n_compared, cyc;
	execution_trace_buffer #(.AW(AW), .SRAM_BASE(SB)) i_dut (.*);
	etb_core_model #(.AW(AW)) i_model (.*);
	////////////////////////////////////////////////////////////
	always #12.5 pclk = ~pclk;
	// Hang guard well above the roughly 150 cycles needed
	always @(posedge pclk)
	begin
		cyc++;
		if (cyc == 4000)
		begin
			error_cnt++;
			print_verdict();
		end
	end
	task automatic print_verdict();
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e)
		begin
			$display("ERROR %s expected %h seen %h", n, e, g);
			error_cnt++;
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] o, input logic [31:0] wd, output logic [31:0] rd,
		output logic er);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= `ETB_BASE_ADDR | 32'(o);
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] o, input logic [31:0] d);
		logic [31:0] r;
		logic        er;
		apb(1'b1, o, d, r, er);
	endtask
	task automatic rdc(input string n, input logic [11:0] o, input logic [31:0] e);
		logic [31:0] r;
		logic        er;
		apb(1'b0, o, 32'h0, r, er);
		chk(n, e, r);
	endtask
	task automatic mem(input string n, input int a, input logic [31:0] e);
		logic [31:0] r;
		i_model.cpu_acc(1'b0, AW'(a), 32'h0, r);
		chk(n, e, r);
	endtask
	// Packet i: source, target, exception flag in bit 0 of the first word
	function automatic logic [31:0] src(input int i);
		return 32'h0800_0100 + 32'(i * 256);
	endfunction
	function automatic logic [31:0] dst(input int i);
		return 32'h0800_2000 + 32'(i * 16);
	endfunction
	task automatic send(input int i);
		i_model.branch(src(i), dst(i), i[0]);
	endtask
	////////////////////////////////////////////////////////////
	initial
	begin
		logic [31:0] r;
		logic        er;
		{pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		rdc("position", `ETB_OFF_POSITION, `ETB_RST_POSITION);
		rdc("master", `ETB_OFF_MASTER, `ETB_RST_MASTER);
		rdc("flow", `ETB_OFF_FLOW, `ETB_RST_FLOW);
		rdc("bufcfg", `ETB_OFF_BUFCFG, `ETB_RST_BUFCFG);
		wr(`ETB_OFF_BASE, 32'h1234_5678);
		rdc("base", `ETB_OFF_BASE, SB);
		apb(1'b0, 12'h014, 32'h0, r, er);
		chk("unmapped err", 32'h1, {31'h0, er});
		$display("register test done");
		send(9);
		repeat (4) @(posedge pclk);
		rdc("position off", `ETB_OFF_POSITION, 32'h0);
		i_model.cpu_acc(1'b1, AW'(100), 32'hcafe_0001, r);
		wr(`ETB_OFF_MASTER, 32'h8000_0003);
		rdc("master en", `ETB_OFF_MASTER, 32'h8000_0003);
		fork
			send(0);
			// One edge later, so the request meets both trace write cycles
			begin
				@(posedge pclk);
				mem("cpu shared", 100, 32'hcafe_0001);
			end
		join
		repeat (4) @(posedge pclk);
		rdc("position one", `ETB_OFF_POSITION, 32'h10);
		for (int i = 1; i < 4; i++) send(i);
		repeat (8) @(posedge pclk);
		rdc("position wrap", `ETB_OFF_POSITION, 32'h4);
		for (int i = 0; i < 4; i++)
		begin
			mem("word0", 2 * i, (src(i) & 32'hffff_fffe) | 32'(i & 1));
			mem("word1", 2 * i + 1, dst(i));
		end
		$display("trace test done");
		wr(`ETB_OFF_MASTER, 32'h0000_0003);
		send(7);
		repeat (4) @(posedge pclk);
		mem("stopped", 1, dst(0));
		wr(`ETB_OFF_FLOW, 32'h0000_001b);
		wr(`ETB_OFF_MASTER, 32'h8000_0003);
		send(4);
		send(5);
		repeat (6) @(posedge pclk);
		chk("halt", 32'h1, {31'h0, halt_req});
		rdc("master stop", `ETB_OFF_MASTER, 32'h0000_0003);
		send(6);
		repeat (4) @(posedge pclk);
		mem("kept", 4, (src(2) & 32'hffff_fffe));
		mem("overwritten", 3, dst(5));
		wr(`ETB_OFF_MASTER, 32'h0000_0003);
		chk("halt held", 32'h1, {31'h0, halt_req});
		wr(`ETB_OFF_MASTER, 32'h8000_0003);
		@(posedge pclk);
		chk("halt clear", 32'h0, {31'h0, halt_req});
		$display("threshold test done");
		print_verdict();
	end
endmodule // tb

// ### inc/etb_params.svh
// Register offsets, field positions and reset values of the execution trace buffer
`ifndef ETB_PARAMS_SVH
`define ETB_PARAMS_SVH
`define ETB_BASE_ADDR       32'h4100_6000
`define ETB_OFF_POSITION    12'h000
`define ETB_OFF_MASTER      12'h004
`define ETB_OFF_FLOW        12'h008
`define ETB_OFF_BASE        12'h00c
`define ETB_OFF_BUFCFG      12'h010
`define ETB_POS_WRAP_BIT    2
`define ETB_POS_PTR_LSB     3
`define ETB_MASTER_EN_BIT   31
`define ETB_MASTER_SIZE_LSB 0
`define ETB_MASTER_SIZE_W   5
`define ETB_FLOW_STOP_BIT   0
`define ETB_FLOW_HALT_BIT   1
`define ETB_FLOW_WM_LSB     3
`define ETB_RST_POSITION    32'h0000_0000
`define ETB_RST_MASTER      32'h0000_0000
`define ETB_RST_FLOW        32'h0000_0000
`define ETB_RST_BUFCFG      32'h0000_0000
`endif

// ### inc/etb_pkg.sv
// Types shared by the execution trace buffer files
package etb_pkg;
	typedef enum logic [1:0] {
		ETB_IDLE,
		ETB_WORD0,
		ETB_WORD1
	} etb_wr_state_type;
	typedef logic [31:0] etb_word_type;
endpackage

// ### rtl/etb_skid_buffer.sv
// Two-entry valid/ready buffer for trace packets
`timescale 1ns/1ps
module etb_skid_buffer #(
	parameter int WIDTH = 64,
	parameter int DEPTH = 2
) (
	input  wire logic             clk,       // Clock
	input  wire logic             rst_n,     // Async reset, low
	input  wire logic             in_valid,  // Source has data
	output logic                  in_ready,  // Room available
	input  wire logic [WIDTH-1:0] in_data,   // Source data
	output logic                  out_valid, // Entry available
	input  wire logic             out_ready, // Sink takes entry
	output logic      [WIDTH-1:0] out_data   // Oldest entry
);
	initial
	begin
		if (DEPTH != 2)
			$error("etb_skid_buffer supports DEPTH 2 only");
	end
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [WIDTH-1:0] mem_d [DEPTH];
	logic             rd_q, rd_d, wr_q, wr_d;
	logic [1:0]       cnt_q, cnt_d;
	logic             push, pop;

	////////////////////////////////////////////////////////////////////////////
	// Pointer and count update; honest full and empty
	always_comb
	begin
		in_ready  = (cnt_q != 2'd2);
		out_valid = (cnt_q != 2'd0);
		out_data  = mem_q[rd_q];
		push      = in_valid && in_ready;
		pop       = out_valid && out_ready;
		mem_d     = mem_q;
		if (push)
			mem_d[wr_q] = in_data;
		wr_d  = push ? ~wr_q : wr_q;
		rd_d  = pop ? ~rd_q : rd_q;
		cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			mem_q[0] <= '0;
			mem_q[1] <= '0;
			rd_q     <= 1'b0;
			wr_q     <= 1'b0;
			cnt_q    <= 2'd0;
		end
		else
		begin
			mem_q <= mem_d;
			rd_q  <= rd_d;
			wr_q  <= wr_d;
			cnt_q <= cnt_d;
		end
	end
endmodule // etb_skid_buffer

// ### rtl/etb_sram.sv
// Single-port trace SRAM array
`timescale 1ns/1ps
module etb_sram #(
	parameter int AW = 10
) (
	input  wire logic          clk,   // Clock
	input  wire logic          en,    // Access strobe
	input  wire logic          we,    // Write enable
	input  wire logic [AW-1:0] addr,  // Word address
	input  wire logic [31:0]   wdata, // Write data
	output logic      [31:0]   rdata  // Read data, one cycle later
);
	logic [31:0] mem [2**AW];
	logic [31:0] rdata_q;

	// Synchronous read and write; array needs no reset
	always_ff @(posedge clk)
	begin
		if (en && we)
			mem[addr] <= wdata;
		if (en && !we)
			rdata_q <= mem[addr];
	end
	assign rdata = rdata_q;
endmodule // etb_sram

// ### rtl/execution_trace_buffer.sv
// Execution trace recorder with shared SRAM and APB register slave
//
// Contract
// - While enabled, capture program-flow changes from the trace interface into SRAM.
// - Packet is two 32-bit words, made only on non-sequential PC change.
// - Trace writes win SRAM arbitration over processor accesses.
// - Processor reads and writes of the SRAM keep working during tracing.
// - Recording active exactly while the master enable bit reads one; here a packet's second word is still written after the bit clears.
// - Software or debugger starts or stops recording by writing the enable bit.
// - With stop-at-threshold, tracing stops when write pointer reaches threshold; here only on the write of a packet's second word at that address.
// - Without threshold stop, pointer wraps to buffer start, overwriting old packets.
// - Registers decoded at base address 0x41006000 with fixed offsets.
// - Four programmable registers: position, master, threshold control, SRAM location; here location is read-only and a fifth, bufcfg, holds the buffer start.
// - Position register holds write pointer and a wrapped flag.
// - Threshold register holds threshold address, stop bit and halt bit.
// - Location register reports where trace SRAM sits in memory map.
// - Software configures buffer start position and size in SRAM.
//
// Local design decisions: the APB register port and the register offsets.
`timescale 1ns/1ps
`include "etb_params.svh"
module execution_trace_buffer
	import etb_pkg::*;
#(
	parameter int          AW        = 10,           // SRAM word address width
	parameter etb_word_type SRAM_BASE = 32'h2000_0000 // SRAM place in memory map
) (
	input  wire logic         pclk,          // APB clock
	input  wire logic         presetn,       // Async reset, low
	input  wire logic         psel,          // APB select
	input  wire logic         penable,       // APB access phase
	input  wire logic         pwrite,        // APB direction
	input  wire logic [31:0]  paddr,         // APB byte address
	input  wire logic [31:0]  pwdata,        // APB write data
	output logic              pready,        // APB ready
	output etb_pkg::etb_word_type prdata,    // APB read data
	output logic              pslverr,       // APB error
	input  wire logic         trace_valid,   // Non-sequential PC change
	input  wire logic [31:0]  trace_src_pc,  // PC of branch source
	input  wire logic [31:0]  trace_dst_pc,  // PC of branch target
	input  wire logic         trace_excp,    // Change due to exception entry
	output logic              trace_ready,   // Recorder can take event
	input  wire logic         cpu_req,       // Processor SRAM request
	input  wire logic         cpu_we,        // Processor write
	input  wire logic [AW-1:0] cpu_addr,     // Processor word address
	input  wire logic [31:0]  cpu_wdata,     // Processor write data
	output logic              cpu_gnt,       // Processor request taken
	output etb_pkg::etb_word_type cpu_rdata, // Processor read data
	output logic              cpu_rvalid,    // Processor read data valid
	output logic              halt_req       // Halt request to debug logic
);
	initial
	begin
		if (AW < 4 || AW > 20)
			$error("execution_trace_buffer: AW out of range");
	end

	logic [31:0]     position_q, position_d;
	logic [31:0]     master_q, master_d;
	logic [31:0]     flow_q, flow_d;
	logic [31:0]     bufcfg_q, bufcfg_d;
	logic            halt_q, halt_d;
	logic            rvalid_q, rvalid_d;
	etb_wr_state_type st_q, st_d;
	logic [31:0]     hold_q, hold_d;
	logic [31:0]     prdata_q, prdata_d;

	logic            fb_out_valid, fb_out_ready;
	logic [63:0]     fb_out_data;
	logic            fb_in_valid;
	logic            trace_we;
	logic [AW-1:0]   trace_addr;
	logic [31:0]     trace_wdata;
	logic            mem_en, mem_we;
	logic [AW-1:0]   mem_addr;
	logic [31:0]     mem_wdata;
	logic            wr_access, rd_access;
	logic            tracing;
	logic [AW-1:0]   ptr, ptr_next, buf_start, buf_end, wm;
	logic [AW:0]     buf_words;

	// Offset within the register window, or all ones when outside it
	function automatic logic [11:0] reg_offset(input logic [31:0] a);
		if (a[31:12] == `ETB_BASE_ADDR >> 12)
			reg_offset = a[11:0];
		else
			reg_offset = 12'hfff;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Buffer geometry: start word and power-of-two size
	always_comb
	begin
		buf_start = bufcfg_q[AW-1:0];
		buf_words = (AW+1)'(1) << master_q[`ETB_MASTER_SIZE_LSB +: `ETB_MASTER_SIZE_W];
		if (buf_words > (AW+1)'(1 << AW) || buf_words < (AW+1)'(2))
			buf_words = (AW+1)'(2);
		buf_end  = AW'(buf_start + buf_words[AW-1:0] - AW'(1));
		ptr      = position_q[`ETB_POS_PTR_LSB +: AW];
		wm       = flow_q[`ETB_FLOW_WM_LSB +: AW];
		tracing  = master_q[`ETB_MASTER_EN_BIT];
		ptr_next = (ptr == buf_end) ? buf_start : AW'(ptr + AW'(1));
	end

	////////////////////////////////////////////////////////////////////////////
	// Packet capture; a stall in the writer backs up into the buffer
	assign fb_in_valid = trace_valid && tracing;
	etb_skid_buffer #(
		.WIDTH (64),
		.DEPTH (2)
	) u_fifo (
		.clk       (pclk),
		.rst_n     (presetn),
		.in_valid  (fb_in_valid),
		.in_ready  (trace_ready),
		.in_data   ({trace_dst_pc, trace_src_pc[31:1], trace_excp}),
		.out_valid (fb_out_valid),
		.out_ready (fb_out_ready),
		.out_data  (fb_out_data)
	);

	////////////////////////////////////////////////////////////////////////////
	// Packet writer: source word then target word
	always_comb
	begin
		st_d         = st_q;
		hold_d       = hold_q;
		fb_out_ready = 1'b0;
		trace_we     = 1'b0;
		trace_wdata  = 32'h0000_0000;
		unique case (st_q)
			ETB_IDLE:
			begin
				if (fb_out_valid && tracing)
				begin
					fb_out_ready = 1'b1;
					hold_d       = fb_out_data[63:32];
					trace_we     = 1'b1;
					trace_wdata  = fb_out_data[31:0];
					st_d         = ETB_WORD1;
				end
			end
			ETB_WORD0:
				st_d = ETB_IDLE;
			ETB_WORD1:
			begin
				trace_we    = 1'b1;
				trace_wdata = hold_q;
				st_d        = ETB_IDLE;
			end
		endcase
	end
	assign trace_addr = ptr;

	////////////////////////////////////////////////////////////////////////////
	// SRAM arbitration: trace write first, processor otherwise
	always_comb
	begin
		cpu_gnt   = cpu_req && !trace_we;
		mem_en    = trace_we || cpu_req;
		mem_we    = trace_we || cpu_we;
		mem_addr  = trace_we ? trace_addr : cpu_addr;
		mem_wdata = trace_we ? trace_wdata : cpu_wdata;
		rvalid_d  = cpu_gnt && !cpu_we;
	end
	etb_sram #(
		.AW (AW)
	) u_sram (
		.clk   (pclk),
		.en    (mem_en),
		.we    (mem_we),
		.addr  (mem_addr),
		.wdata (mem_wdata),
		.rdata (cpu_rdata)
	);
	assign cpu_rvalid = rvalid_q;

	////////////////////////////////////////////////////////////////////////////
	// APB slave: zero wait states, error on unmapped offset
	always_comb
	begin
		wr_access = psel && penable && pwrite;
		rd_access = psel && !penable && !pwrite;
		pready    = 1'b1;
		pslverr   = 1'b0;
		if (psel && penable)
		begin
			unique case (reg_offset(paddr))
				`ETB_OFF_POSITION, `ETB_OFF_MASTER, `ETB_OFF_FLOW,
				`ETB_OFF_BASE, `ETB_OFF_BUFCFG:
					pslverr = 1'b0;
				default:
					pslverr = 1'b1;
			endcase
		end
		prdata_d = prdata_q;
		if (rd_access)
		begin
			unique case (reg_offset(paddr))
				`ETB_OFF_POSITION: prdata_d = position_q;
				`ETB_OFF_MASTER:   prdata_d = master_q;
				`ETB_OFF_FLOW:     prdata_d = flow_q;
				`ETB_OFF_BASE:     prdata_d = SRAM_BASE;
				`ETB_OFF_BUFCFG:   prdata_d = bufcfg_q;
				default:           prdata_d = 32'h0000_0000;
			endcase
		end
	end
	assign prdata = prdata_q;

	////////////////////////////////////////////////////////////////////////////
	// Register and pointer update; hardware events win over software writes
	always_comb
	begin
		position_d = position_q;
		master_d   = master_q;
		flow_d     = flow_q;
		bufcfg_d   = bufcfg_q;
		halt_d     = halt_q;
		if (wr_access)
		begin
			unique case (reg_offset(paddr))
				`ETB_OFF_POSITION: position_d = pwdata & {{(29-AW){1'b0}}, {AW{1'b1}}, 3'b100};
				`ETB_OFF_MASTER:   master_d   = pwdata & 32'h8000_001f;
				`ETB_OFF_FLOW:     flow_d     = pwdata & {{(29-AW){1'b0}}, {AW{1'b1}}, 3'b011};
				`ETB_OFF_BUFCFG:   bufcfg_d   = pwdata & {{(32-AW){1'b0}}, {AW{1'b1}}};
				default:           halt_d     = halt_q;
			endcase
		end
		// Clear first, so that a threshold hit in the same cycle still raises the halt
		if (wr_access && reg_offset(paddr) == `ETB_OFF_MASTER && pwdata[`ETB_MASTER_EN_BIT])
			halt_d = 1'b0;
		if (trace_we)
		begin
			position_d[`ETB_POS_PTR_LSB +: AW] = ptr_next;
			if (ptr == buf_end)
				position_d[`ETB_POS_WRAP_BIT] = 1'b1;
			if (ptr == wm && st_q == ETB_WORD1)
			begin
				if (flow_q[`ETB_FLOW_STOP_BIT])
					master_d[`ETB_MASTER_EN_BIT] = 1'b0;
				if (flow_q[`ETB_FLOW_HALT_BIT])
					halt_d = 1'b1;
			end
		end
	end
	assign halt_req = halt_q;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			position_q <= `ETB_RST_POSITION;
			master_q   <= `ETB_RST_MASTER;
			flow_q     <= `ETB_RST_FLOW;
			bufcfg_q   <= `ETB_RST_BUFCFG;
			halt_q     <= 1'b0;
			rvalid_q   <= 1'b0;
			st_q       <= ETB_IDLE;
			hold_q     <= 32'h0000_0000;
			prdata_q   <= 32'h0000_0000;
		end
		else
		begin
			position_q <= position_d;
			master_q   <= master_d;
			flow_q     <= flow_d;
			bufcfg_q   <= bufcfg_d;
			halt_q     <= halt_d;
			rvalid_q   <= rvalid_d;
			st_q       <= st_d;
			hold_q     <= hold_d;
			prdata_q   <= prdata_d;
		end
	end
endmodule // execution_trace_buffer
